// ===== rtl/gear_accum.sv
// per-axis sub-pulse accumulator and pulse emitter
`timescale 1ns/1ps
`include "gear_defines.svh"

module gear_accum (
  input  wire logic        ref_clk_in,     // 40 MHz clock
  input  wire logic        rst_in,         // asynchronous reset, active high
  input  wire logic        tick_in,        // pulse rate enable
  input  wire logic [15:0] ppr_in,         // active pulses per rotation
  input  wire logic [25:0] den_in,         // active travel per rotation times multiplier
  input  wire logic        near_mode_in,   // 1: near pass joining
  input  wire logic        clear_in,       // clear remainder
  input  wire logic        step_valid_in,  // travel step offered
  input  wire logic [15:0] step_amount_in, // signed travel in least units
  input  wire logic        seg_end_in,     // last step of a segment given
  output logic             step_ready_out, // step taken when valid
  output logic             pulse_out,      // one-cycle command pulse
  output logic             dir_out,        // 1: reverse
  output logic      [15:0] remainder_out,  // low bits of remainder
  output logic             aligning_out    // end-of-segment alignment running
);

  gear_pkg::acc_state_t state_q;
  logic signed [34:0]   acc_q;
  logic signed [34:0]   den_s;
  logic signed [34:0]   prod_s;
  logic                 can_fwd;
  logic                 can_rev;
  logic                 accept;
  logic                 drained;

  // travel counted in numerator units: step*ppr against tpr*mult, no rounding
  assign den_s   = $signed({9'h000, den_in});
  // both factors widened first so the product is formed at full width, never truncated
  assign prod_s  = $signed({{19{step_amount_in[15]}}, step_amount_in})
                   * $signed({19'h0_0000, ppr_in});
  assign can_fwd = (den_in != 26'h0) && (acc_q >= den_s);
  assign can_rev = (den_in != 26'h0) && (acc_q <= -den_s);
  assign accept  = step_valid_in && step_ready_out;
  assign drained = !can_fwd && !can_rev;

  // accumulator: clear first, then pulse payout, then new travel
  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
      acc_q <= '0;
    else if (clear_in)
      acc_q <= '0;
    else if (tick_in && can_fwd)
      acc_q <= acc_q - den_s;
    else if (tick_in && can_rev)
      acc_q <= acc_q + den_s;
    else if (accept)
      acc_q <= acc_q + prod_s;
    else if (state_q == gear_pkg::ACC_ALIGN && drained)
      acc_q <= '0;
  end

  // exact mode stalls at a segment end; near mode carries the remainder on
  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
      state_q <= gear_pkg::ACC_RUN;
    else
      unique case (state_q)
        gear_pkg::ACC_RUN:
          if (seg_end_in && !near_mode_in)
            state_q <= gear_pkg::ACC_ALIGN;
        gear_pkg::ACC_ALIGN:
          if (drained || clear_in)
            state_q <= gear_pkg::ACC_RUN;
      endcase
  end

  // registered ready; dropped after each step and held low until the pulses have drained so acc settles
  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
      step_ready_out <= 1'b0;
    else
      step_ready_out <= !accept && !clear_in && drained && state_q == gear_pkg::ACC_RUN
                        && !(seg_end_in && !near_mode_in);
  end

  // pulse and direction outputs
  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      pulse_out <= 1'b0;
      dir_out   <= 1'b0;
    end
    else
    begin
      pulse_out <= tick_in && !clear_in && !drained;
      if (tick_in && can_rev)
        dir_out <= 1'b1;
      else if (tick_in && can_fwd)
        dir_out <= 1'b0;
    end
  end

  // status copies
  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      remainder_out <= 16'h0000;
      aligning_out  <= 1'b0;
    end
    else
    begin
      remainder_out <= acc_q[15:0];
      aligning_out  <= (state_q == gear_pkg::ACC_ALIGN);
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  a_clear_zeroes: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    clear_in |=> (acc_q == '0))
    else $error("remainder not cleared");

  a_fwd_pays: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (tick_in && can_fwd && !clear_in) |=>
      (pulse_out && !dir_out && acc_q == $past(acc_q) - $past(den_s)))
    else $error("forward pulse not paid out");

  a_no_pulse_idle: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (drained || !tick_in) |=> !pulse_out)
    else $error("pulse without whole pulse pending");

  a_exact_stalls: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (state_q == gear_pkg::ACC_ALIGN) |-> !step_ready_out)
    else $error("step taken while aligning");

  a_near_no_align: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (near_mode_in && state_q == gear_pkg::ACC_RUN && seg_end_in) |=>
      (state_q == gear_pkg::ACC_RUN))
    else $error("near mode entered alignment");

  a_step_adds: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (accept && !clear_in) |=> (acc_q == $past(acc_q) + $past(prod_s)))
    else $error("step travel not added exactly");

endmodule

// ===== rtl/gear_defines.svh
// constants for the electronic gear and path join block
`ifndef GEAR_DEFINES_SVH
`define GEAR_DEFINES_SVH

// ****************************************************************
// register map (byte addresses)
// ****************************************************************
`define AXIS_STRIDE       8'h10
`define REG_PPR_OFS       8'h00
`define REG_TPR_OFS       8'h04
`define REG_CFG_OFS       8'h08
`define REG_STAT_OFS      8'h0C
`define REG_CMD_ADDR      8'h40
`define REG_GSTAT_ADDR    8'h44

// ****************************************************************
// field positions
// ****************************************************************
`define CFG_MULT_LSB      0
`define CFG_UNIT_LSB      2
`define CFG_PATH_BIT      4
`define STAT_ALIGN_BIT    16
`define STAT_NEAR_BIT     17
`define STAT_READY_BIT    18

// ****************************************************************
// reset values
// ****************************************************************
`define PPR_RESET         16'h4E20
`define TPR_RESET         16'h4E20
`define CFG_RESET         5'h00

// ****************************************************************
// unit multiplier values selected by the two-bit code
// ****************************************************************
`define MULT_X1           10'h001
`define MULT_X10          10'h00A
`define MULT_X100         10'h064
`define MULT_X1000        10'h3E8

// ****************************************************************
// timing
// ****************************************************************
`define CLK_HZ            40000000
`define PULSE_MAX_HZ      1000000
`define PULSE_MIN_CYCLES  ((`CLK_HZ + `PULSE_MAX_HZ - 1) / `PULSE_MAX_HZ)

`endif

// ===== rtl/gear_path_top.sv
// electronic gear scaling and path join selection, per axis, wishbone slave
// Functional notes
// - keep sub-pulse travel, output whole pulses, retain only the fraction
// - fixed-dimension feed start clears the sub-pulse remainder
// - a current-value change clears the sub-pulse remainder
// - travel per pulse is travel per rotation over pulses, times multiplier
// - written parameters take effect only on host ready rising edge
// - travel value one is the least unit step, 0.1 um for millimetres
// - path join mode parameter selects exact or near passing
// - exact mode, the reset default, aligns to every segment target
// - near mode carries leftover travel into the next segment
// - near mode keeps output speed up between segments
// - every axis has its own copy of all parameters
//
// Design decisions made here: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
`include "gear_defines.svh"

module gear_path_top #(
  parameter int NUM_AXES = 2
) (
  input  wire logic                     ref_clk_in,     // 40 MHz clock
  input  wire logic                     rst_in,         // asynchronous reset, active high
  input  wire logic                     wb_cyc_in,      // wishbone cycle
  input  wire logic                     wb_stb_in,      // wishbone strobe
  input  wire logic                     wb_we_in,       // wishbone write
  input  wire logic [7:0]               wb_adr_in,      // byte address
  input  wire logic [3:0]               wb_sel_in,      // byte enables
  input  wire logic [31:0]              wb_dat_in,      // write data
  output logic      [31:0]              wb_dat_out,     // read data
  output logic                          wb_ack_out,     // acknowledge
  input  wire logic                     host_ready_in,  // host ready pin, asynchronous
  input  wire logic [NUM_AXES-1:0]      step_valid_in,  // travel step offered per axis
  input  wire logic [NUM_AXES*16-1:0]   step_amount_in, // signed travel per axis
  input  wire logic [NUM_AXES-1:0]      seg_end_in,     // segment end per axis
  output logic      [NUM_AXES-1:0]      step_ready_out, // step taken per axis
  output logic      [NUM_AXES-1:0]      pulse_out,      // command pulse per axis
  output logic      [NUM_AXES-1:0]      dir_out         // direction per axis, 1 reverse
);

  if (NUM_AXES < 1 || NUM_AXES > 4)
  begin : g_bad_axes
    $error("gear_path_top serves one to four axes");
  end

  // ****************************************************************
  // parameter storage, staged and active, one set per axis
  // ****************************************************************
  logic [15:0] ppr_stage_q   [NUM_AXES];
  logic [15:0] tpr_stage_q   [NUM_AXES];
  logic [4:0]  cfg_stage_q   [NUM_AXES];
  logic [15:0] ppr_act_q     [NUM_AXES];
  logic [25:0] den_act_q     [NUM_AXES];
  logic [1:0]  unit_act_q    [NUM_AXES];
  gear_pkg::path_mode_t mode_act_q [NUM_AXES];
  logic [15:0] remainder_w   [NUM_AXES];
  logic [NUM_AXES-1:0] aligning_w;
  logic [NUM_AXES-1:0] feed_clr_q;
  logic [NUM_AXES-1:0] value_clr_q;
  logic        rdy_meta_q;
  logic        rdy_sync_q;
  logic        rdy_prev_q;
  logic        apply;
  logic        wr_en;
  logic        tick;
  logic [2:0]  sel_axis;
  logic [3:0]  sel_ofs;
  logic        in_axes;

  localparam logic [4:0] cfg_rst = `CFG_RESET;

  // multiplier code to value
  function automatic logic [9:0] mult_of(input logic [1:0] code);
    logic [9:0] m;
    m = `MULT_X1;
    case (code)
      2'h1:    m = `MULT_X10;
      2'h2:    m = `MULT_X100;
      2'h3:    m = `MULT_X1000;
      default: m = `MULT_X1;
    endcase
    return m;
  endfunction

  // merge write data into a field under the byte enables
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] dat,
                                          input logic [3:0] sel);
    logic [15:0] r;
    r = old;
    if (sel[0])
      r[7:0] = dat[7:0];
    if (sel[1])
      r[15:8] = dat[15:8];
    return r;
  endfunction

  assign wr_en    = wb_cyc_in && wb_stb_in && wb_we_in && !wb_ack_out;
  assign sel_axis = wb_adr_in[6:4];
  assign sel_ofs  = wb_adr_in[3:0];
  assign in_axes  = !wb_adr_in[7] && ({5'h00, sel_axis} < 8'(NUM_AXES))
                    && (wb_adr_in < 8'(NUM_AXES * 16));
  assign apply    = rdy_sync_q && !rdy_prev_q;

  // ****************************************************************
  // host ready synchroniser and rising edge
  // ****************************************************************
  // the edge is taken from the second stage so only it reads the first
  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      rdy_meta_q <= 1'b0;
      rdy_sync_q <= 1'b0;
      rdy_prev_q <= 1'b0;
    end
    else
    begin
      rdy_meta_q <= host_ready_in;
      rdy_sync_q <= rdy_meta_q;
      rdy_prev_q <= rdy_sync_q;
    end
  end

  // ****************************************************************
  // staged registers written by software
  // ****************************************************************
  // staged values steer nothing until host ready rises
  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      for (int a = 0; a < NUM_AXES; a++)
      begin
        ppr_stage_q[a] <= `PPR_RESET;
        tpr_stage_q[a] <= `TPR_RESET;
        cfg_stage_q[a] <= `CFG_RESET;
      end
    end
    else if (wr_en && in_axes)
    begin
      for (int a = 0; a < NUM_AXES; a++)
      begin
        if (3'(a) == sel_axis)
        begin
          if (sel_ofs == 4'(`REG_PPR_OFS))
            ppr_stage_q[a] <= merge16(ppr_stage_q[a], wb_dat_in, wb_sel_in);
          if (sel_ofs == 4'(`REG_TPR_OFS))
            tpr_stage_q[a] <= merge16(tpr_stage_q[a], wb_dat_in, wb_sel_in);
          if (sel_ofs == 4'(`REG_CFG_OFS) && wb_sel_in[0])
            cfg_stage_q[a] <= wb_dat_in[4:0];
        end
      end
    end
  end

  // ****************************************************************
  // active copies, loaded on host ready rising edge
  // ****************************************************************
  // denominator formed once at load so the datapath never divides
  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      for (int a = 0; a < NUM_AXES; a++)
      begin
        ppr_act_q[a]  <= `PPR_RESET;
        den_act_q[a]  <= 26'(`TPR_RESET) * 26'(`MULT_X1);
        unit_act_q[a] <= cfg_rst[`CFG_UNIT_LSB +: 2];
        mode_act_q[a] <= gear_pkg::PATH_EXACT;
      end
    end
    else if (apply)
    begin
      for (int a = 0; a < NUM_AXES; a++)
      begin
        ppr_act_q[a]  <= ppr_stage_q[a];
        den_act_q[a]  <= 26'(tpr_stage_q[a]) * 26'(mult_of(cfg_stage_q[a][1:0]));
        unit_act_q[a] <= cfg_stage_q[a][3:2];
        mode_act_q[a] <= gear_pkg::path_mode_t'(cfg_stage_q[a][`CFG_PATH_BIT]);
      end
    end
  end

  // ****************************************************************
  // command register: write-one pulses per axis
  // ****************************************************************
  // bit 2a starts a fixed feed, bit 2a+1 marks a current-value change
  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      feed_clr_q  <= '0;
      value_clr_q <= '0;
    end
    else
    begin
      for (int a = 0; a < NUM_AXES; a++)
      begin
        feed_clr_q[a]  <= wr_en && wb_adr_in == `REG_CMD_ADDR && wb_sel_in[0]
                          && wb_dat_in[2*a];
        value_clr_q[a] <= wr_en && wb_adr_in == `REG_CMD_ADDR && wb_sel_in[0]
                          && wb_dat_in[2*a+1];
      end
    end
  end

  // ****************************************************************
  // wishbone answer: one wait state, zero for unmapped
  // ****************************************************************
  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_out <= wb_cyc_in && wb_stb_in && !wb_ack_out;
      wb_dat_out <= 32'h0000_0000;
      if (wb_adr_in == `REG_GSTAT_ADDR)
        wb_dat_out <= {31'h0000_0000, rdy_sync_q};
      else if (in_axes)
      begin
        for (int a = 0; a < NUM_AXES; a++)
        begin
          if (3'(a) == sel_axis)
          begin
            unique case (sel_ofs)
              4'(`REG_PPR_OFS):  wb_dat_out <= {16'h0000, ppr_stage_q[a]};
              4'(`REG_TPR_OFS):  wb_dat_out <= {16'h0000, tpr_stage_q[a]};
              4'(`REG_CFG_OFS):  wb_dat_out <= {27'h000_0000, cfg_stage_q[a]};
              4'(`REG_STAT_OFS): wb_dat_out <= {13'h0000, step_ready_out[a],
                                                mode_act_q[a] == gear_pkg::PATH_NEAR,
                                                aligning_w[a], remainder_w[a]};
              default:           wb_dat_out <= 32'h0000_0000;
            endcase
          end
        end
      end
    end
  end

  // ****************************************************************
  // pulse rate and per-axis accumulators
  // ****************************************************************
  // pacing caps output at the servo limit; slower gears simply idle between ticks
  rate_divider #(
    .DIV_CYCLES (`PULSE_MIN_CYCLES)
  ) rate_divider_i (
    .ref_clk_in (ref_clk_in),
    .rst_in     (rst_in),
    .tick_out   (tick)
  );

  for (genvar g = 0; g < NUM_AXES; g++)
  begin : g_axis
    // step amounts are in least units of the axis unit, so value one is one step
    gear_accum gear_accum_i (
      .ref_clk_in     (ref_clk_in),
      .rst_in         (rst_in),
      .tick_in        (tick),
      .ppr_in         (ppr_act_q[g]),
      .den_in         (den_act_q[g]),
      .near_mode_in   (mode_act_q[g] == gear_pkg::PATH_NEAR),
      .clear_in       (feed_clr_q[g] || value_clr_q[g]),
      .step_valid_in  (step_valid_in[g]),
      .step_amount_in (step_amount_in[g*16 +: 16]),
      .seg_end_in     (seg_end_in[g]),
      .step_ready_out (step_ready_out[g]),
      .pulse_out      (pulse_out[g]),
      .dir_out        (dir_out[g]),
      .remainder_out  (remainder_w[g]),
      .aligning_out   (aligning_w[g])
    );
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  a_ack_single: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    wb_ack_out |=> !wb_ack_out)
    else $error("ack held two cycles");

  a_apply_edge_only: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    !apply |=> (ppr_act_q[0] == $past(ppr_act_q[0]) && den_act_q[0] == $past(den_act_q[0])))
    else $error("active gear changed without host ready edge");

  a_apply_loads: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    apply |=> (den_act_q[0] == 26'($past(tpr_stage_q[0]))
               * 26'(mult_of($past(cfg_stage_q[0][1:0])))))
    else $error("denominator not formed on apply");

  a_mode_loads: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    apply |=> (mode_act_q[0] == gear_pkg::path_mode_t'($past(cfg_stage_q[0][`CFG_PATH_BIT]))))
    else $error("path mode not loaded on apply");

  a_cmd_clear: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (wr_en && wb_adr_in == `REG_CMD_ADDR && wb_sel_in[0] && wb_dat_in[1]) |=> value_clr_q[0])
    else $error("value change did not clear");

endmodule

// ===== rtl/gear_pkg.sv
// types shared by the electronic gear and path join block
package gear_pkg;

  typedef enum logic {PATH_EXACT, PATH_NEAR} path_mode_t;

  typedef enum logic [1:0] {UNIT_MM, UNIT_INCH, UNIT_DEGREE, UNIT_PULSE} unit_sel_t;

  typedef enum logic {ACC_RUN, ACC_ALIGN} acc_state_t;

endpackage

// ===== rtl/rate_divider.sv
// one-cycle enable pulse every DIV_CYCLES clocks
`timescale 1ns/1ps
`include "gear_defines.svh"

module rate_divider #(
  parameter int DIV_CYCLES = `PULSE_MIN_CYCLES
) (
  input  wire logic ref_clk_in, // 40 MHz clock
  input  wire logic rst_in,     // asynchronous reset, active high
  output logic      tick_out    // one-cycle enable
);

  localparam int CW = $clog2(DIV_CYCLES + 1);

  logic [CW-1:0] count_q;

  if (DIV_CYCLES < 2)
  begin : g_bad_div
    $error("rate_divider needs at least two cycles per tick");
  end

  // free-running down counter, reload on terminal count
  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      count_q  <= '0;
      tick_out <= 1'b0;
    end
    else if (count_q == '0)
    begin
      count_q  <= CW'(DIV_CYCLES - 1);
      tick_out <= 1'b1;
    end
    else
    begin
      count_q  <= count_q - 1'b1;
      tick_out <= 1'b0;
    end
  end

endmodule

// ===== sim/electronic_gear_path_mode_tb.sv
// self-checking bench for the electronic gear and path join block
`timescale 1ns/1ps

module electronic_gear_path_mode_tb;
  logic        ref_clk_in, rst_in, wb_cyc, wb_stb, wb_we, wb_ack, host_ready, gap_err;
  logic [7:0]  wb_adr;
  logic [3:0]  wb_sel;
  logic [31:0] wb_wdat, wb_rdat, rd, sa, pos;
  logic [1:0]  sv, se, sr, pl, dr;
  int          mismatches, comparisons, cycles;

  gear_path_top #(.NUM_AXES(2)) gear_path_top_i (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .wb_cyc_in(wb_cyc), .wb_stb_in(wb_stb), .wb_we_in(wb_we), .wb_adr_in(wb_adr),
    .wb_sel_in(wb_sel), .wb_dat_in(wb_wdat), .wb_dat_out(wb_rdat), .wb_ack_out(wb_ack),
    .host_ready_in(host_ready), .step_valid_in(sv), .step_amount_in(sa), .seg_end_in(se),
    .step_ready_out(sr), .pulse_out(pl), .dir_out(dr));
  servo_model #(.NUM_AXES(2), .MIN_GAP(40)) servo_model_i (.ref_clk_in(ref_clk_in),
    .rst_in(rst_in), .pulse_in(pl), .dir_in(dr), .pos_out(pos), .gap_err_out(gap_err));

  // 25 ns clock
  initial
  begin
    ref_clk_in = 1'b0;
    forever #12.5 ref_clk_in = ~ref_clk_in;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("counts: %0d compared, %0d mismatched", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // classic single cycle; the slave answers when it will, the timeout guards the wait
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_in);
    wb_cyc <= 1'b1; wb_stb <= 1'b1; wb_we <= w; wb_adr <= a; wb_wdat <= d; wb_sel <= 4'hF;
    do @(posedge ref_clk_in); while (wb_ack !== 1'b1);
    rd = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask

  // offer a step, hold until taken, then wait for the pulses to drain
  task automatic step(input int ax, input logic [15:0] amt);
    @(posedge ref_clk_in);
    sv[ax] <= 1'b1;
    sa[ax*16 +: 16] <= amt;
    do @(posedge ref_clk_in); while (sr[ax] !== 1'b1);
    sv[ax] <= 1'b0;
    repeat (2) @(posedge ref_clk_in);
    while (sr[ax] !== 1'b1) @(posedge ref_clk_in);
  endtask

  task automatic seg_end();
    @(posedge ref_clk_in);
    se[0] <= 1'b1;
    @(posedge ref_clk_in);
    se[0] <= 1'b0;
    repeat (2) @(posedge ref_clk_in);
    while (sr[0] !== 1'b1) @(posedge ref_clk_in);
  endtask

  // fresh off-to-on edge of host ready; sync plus edge detect needs three edges
  task automatic ready_edge();
    @(posedge ref_clk_in);
    host_ready <= 1'b0;
    repeat (4) @(posedge ref_clk_in);
    host_ready <= 1'b1;
    repeat (8) @(posedge ref_clk_in);
  endtask

  task automatic rem(input logic [15:0] exp);
    wb(1'b0, 8'h0C, 32'h0);
    chk({16'h0, rd[15:0]}, {16'h0, exp});
  endtask

  // hang guard at 60000 cycles, far above the expected run
  always @(posedge ref_clk_in)
  begin
    cycles <= cycles + 1;
    if (cycles == 60000)
    begin
      mismatches++;
      stop_test();
    end
  end

  initial
  begin
    {wb_cyc, wb_stb, wb_we, host_ready} = 4'h0;
    {wb_adr, wb_sel, wb_wdat, sv, se, sa} = '0;
    {mismatches, comparisons, cycles} = '0;
    rst_in = 1'b1;
    repeat (4) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    wb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h00004E20);
    wb(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h00000000);
    wb(1'b0, 8'h0C, 32'h0);
    chk({31'h0, rd[17]}, 32'h0);
    wb(1'b0, 8'h80, 32'h0);
    chk(rd, 32'h00000000);
    $display("test reset done");
    // staged gear of 3 travel over 2 pulses must not act before the ready edge
    wb(1'b1, 8'h00, 32'h00000002);
    wb(1'b1, 8'h04, 32'h00000003);
    step(0, 16'h0001);
    chk(pos[15:0], 16'h0001);
    rem(16'h0000);
    ready_edge();
    wb(1'b0, 8'h44, 32'h0);
    chk(rd, 32'h00000001);
    step(0, 16'h0001);
    chk(pos[15:0], 16'h0001);
    rem(16'h0002);
    step(0, 16'h0001);
    chk(pos[15:0], 16'h0002);
    rem(16'h0001);
    step(0, 16'h0001);
    chk(pos[15:0], 16'h0003);
    rem(16'h0000);
    $display("test gear ratio done");
    // clears: a surviving remainder of 2 would add a pulse on the next step
    step(0, 16'h0001);
    wb(1'b1, 8'h40, 32'h00000001);
    rem(16'h0000);
    step(0, 16'h0001);
    chk(pos[15:0], 16'h0003);
    wb(1'b1, 8'h40, 32'h00000002);
    rem(16'h0000);
    step(0, 16'h0001);
    seg_end();
    rem(16'h0000);
    $display("test clears done");
    // near mode with x10: den 10, step 6 gives 12, one pulse, remainder 2 carried
    wb(1'b1, 8'h08, 32'h00000011);
    wb(1'b1, 8'h04, 32'h00000001);
    ready_edge();
    wb(1'b0, 8'h0C, 32'h0);
    chk({31'h0, rd[17]}, 32'h1);
    step(0, 16'h0006);
    chk(pos[15:0], 16'h0004);
    seg_end();
    rem(16'h0002);
    step(0, 16'hFFFA);
    chk(pos[15:0], 16'h0003);
    $display("test near mode done");
    // second axis keeps its own parameters, then walks the x100 and x1000 codes
    step(1, 16'h0001);
    chk(pos[31:16], 16'h0001);
    wb(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h00004E20);
    wb(1'b1, 8'h10, 32'h000003E8);
    wb(1'b1, 8'h14, 32'h0000000A);
    wb(1'b1, 8'h18, 32'h00000002);
    ready_edge();
    step(1, 16'h0001);
    chk(pos[31:16], 16'h0002);
    wb(1'b1, 8'h14, 32'h00000001);
    wb(1'b1, 8'h18, 32'h00000003);
    ready_edge();
    step(1, 16'h0001);
    chk(pos[31:16], 16'h0003);
    chk(pos[15:0], 16'h0003);
    wb(1'b0, 8'h0C, 32'h0);
    chk({31'h0, rd[17]}, 32'h1);
    chk({31'h0, gap_err}, 32'h0);
    $display("test axes done");
    stop_test();
  end
endmodule

// ===== sim/servo_model.sv
// servo amplifier stand-in that follows command pulses and watches their rate
`timescale 1ns/1ps

module servo_model #(
  parameter int NUM_AXES = 2,
  parameter int MIN_GAP  = 40
) (
  input  wire logic                   ref_clk_in,  // 40 MHz clock
  input  wire logic                   rst_in,      // asynchronous reset, active high
  input  wire logic [NUM_AXES-1:0]    pulse_in,    // command pulse per axis
  input  wire logic [NUM_AXES-1:0]    dir_in,      // 1: reverse
  output logic      [NUM_AXES*16-1:0] pos_out,     // signed pulse position per axis
  output logic                        gap_err_out  // pulses came faster than 1 Mpps
);
  int gap_q [NUM_AXES];

  // position moves one step per pulse; a real amp loses pulses past its rate, so flag it
  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      pos_out <= '0;
      gap_err_out <= 1'b0;
      for (int a = 0; a < NUM_AXES; a++) gap_q[a] <= MIN_GAP;
    end
    else
    begin
      for (int a = 0; a < NUM_AXES; a++)
      begin
        if (pulse_in[a] === 1'b1)
        begin
          pos_out[a*16 +: 16] <= pos_out[a*16 +: 16] + (dir_in[a] ? 16'hFFFF : 16'h0001);
          if (gap_q[a] < MIN_GAP) gap_err_out <= 1'b1;
          gap_q[a] <= 1;
        end
        else if (gap_q[a] < MIN_GAP) gap_q[a] <= gap_q[a] + 1;
      end
    end
  end
endmodule
